// ===== verilog/plc_regs.svh
/*
 Register map, reset values and widths of the parallel line controller.
 Assumes byte addressing on a 32-bit bus; included by bare name.
*/
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH

// ==========================================================
// Widths
`define PLC_LINES 32
`define PLC_ADDR_W 8

// ==========================================================
// Byte offsets
`define PLC_OFS_OUT_ENABLE 8'h10
`define PLC_OFS_OUT_DISABLE 8'h14
`define PLC_OFS_OUT_STATUS 8'h18
`define PLC_OFS_FILT_ENABLE 8'h20
`define PLC_OFS_FILT_DISABLE 8'h24
`define PLC_OFS_FILT_STATUS 8'h28
`define PLC_OFS_SET_OUTPUT 8'h30
`define PLC_OFS_CLEAR_OUTPUT 8'h34
`define PLC_OFS_OUT_DATA 8'h38
`define PLC_OFS_PIN_LEVEL 8'h3c
`define PLC_OFS_IRQ_ENABLE 8'h40
`define PLC_OFS_IRQ_DISABLE 8'h44
`define PLC_OFS_IRQ_MASK 8'h48
`define PLC_OFS_IRQ_STATUS 8'h4c
`define PLC_OFS_OD_ENABLE 8'h50
`define PLC_OFS_OD_DISABLE 8'h54
`define PLC_OFS_OD_STATUS 8'h58
`define PLC_OFS_PU_DISABLE 8'h60
`define PLC_OFS_PU_ENABLE 8'h64
`define PLC_OFS_PU_STATUS 8'h68
`define PLC_OFS_OW_ENABLE 8'ha0
`define PLC_OFS_OW_DISABLE 8'ha4
`define PLC_OFS_OW_STATUS 8'ha8

// ==========================================================
// Reset values
`define PLC_RST_ZERO 32'h0000_0000

`endif

// ===== verilog/plc_pkg.sv
/*
 Types shared by the parallel line controller.
 Assumes the register header supplies the line count.
*/
`include "plc_regs.svh"

package plc_pkg;
   // ==========================================================
   // Line vector and pad drive bundle
   typedef logic [`PLC_LINES-1:0] plc_lines_t;

   typedef struct packed {
      plc_lines_t level;
      plc_lines_t enable;
   } plc_pad_drv_t;
endpackage : plc_pkg

// ===== verilog/plc_line_control.sv
/*
 Parallel line controller: 32 pads, per-line set/clear/status registers,
 glitch filter, open drain, pull-up control and change detection.
 Assumes an Avalon-MM master on the same clock and pads outside the clock.
*/
// Notes on behaviour
// - Each bit acts on its own line only; writing zero changes nothing except in the direct output data register.
// - Output-disable write of one turns the line driver off.
// - Output status reads one for driven lines, zero for inputs.
// - Filter-enable write of one turns on that line's glitch filter.
// - Filter-disable write of one turns off that line's glitch filter.
// - Filter status reads one where the filter is on.
// - Set-output write of one makes the pending drive value one.
// - Clear-output write of one makes the pending drive value zero.
// - Output data status returns the value scheduled for driving.
// - Direct output data write changes only write-permitted lines.
// - Pin level status returns each pad's sampled level, any direction.
// - With clock stopped, pin readback keeps the last captured levels.
// - Interrupt-enable write of one enables change interrupt per line.
// - Interrupt-disable write of one disables change interrupt per line.
// - Interrupt mask reads one where change interrupt is enabled.
// - Change status bit sets when a level change was seen.
// - Reading change status clears its bits, except those with a new change in that cycle.
// - Open-drain-enable write of one selects open-drain drive.
// - Open-drain-disable write of one returns line to push-pull.
// - Open drain drives low only; push-pull drives both levels.
// - Pull-up-disable write of one switches the line pull-up off.
`timescale 1ns/1ps
`include "plc_regs.svh"

module plc_line_control (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [`PLC_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire plc_pkg::plc_lines_t padIn,
   output plc_pkg::plc_pad_drv_t padDrive,
   output plc_pkg::plc_lines_t pullupOn,
   output logic irq
);
   import plc_pkg::*;

   // ==========================================================
   // Bus handshake state
   logic wait_reg;
   logic capture;
   logic accept;
   logic wrAcc;

   // ==========================================================
   // Line state registers
   plc_lines_t outEn_reg;
   plc_lines_t filtEn_reg;
   plc_lines_t outData_reg;
   plc_lines_t irqMask_reg;
   plc_lines_t irqStat_reg;
   plc_lines_t openDrain_reg;
   plc_lines_t pullOff_reg;
   plc_lines_t writePerm_reg;

   // ==========================================================
   // Input path
   plc_lines_t sync1_reg;
   plc_lines_t sync2_reg;
   plc_lines_t prevSamp_reg;
   plc_lines_t filt_reg;
   plc_lines_t level_reg;
   plc_lines_t levelPrev_reg;
   logic primed_reg;
   plc_lines_t stable;
   plc_lines_t filtNext;
   plc_lines_t levelNext;
   plc_lines_t change;
   plc_lines_t readMux;

   // First request cycle loads read data, second one completes it
   assign capture = (read | write) & wait_reg;
   assign accept = (read | write) & ~wait_reg;
   assign wrAcc = write & ~wait_reg;

   // One wait state per transfer; idle waitrequest stays high
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wait_reg <= 1'b1;
      end else if (capture) begin
         wait_reg <= 1'b0;
      end else if (accept) begin
         wait_reg <= 1'b1;
      end
   end

   assign waitrequest = wait_reg;

   // ==========================================================
   // Read data mux, unmapped offsets read zero
   always_comb begin
      readMux = `PLC_RST_ZERO;
      unique case (address)
         `PLC_OFS_OUT_STATUS: readMux = outEn_reg;
         `PLC_OFS_FILT_STATUS: readMux = filtEn_reg;
         `PLC_OFS_OUT_DATA: readMux = outData_reg;
         `PLC_OFS_PIN_LEVEL: readMux = level_reg;
         `PLC_OFS_IRQ_MASK: readMux = irqMask_reg;
         `PLC_OFS_IRQ_STATUS: readMux = irqStat_reg;
         `PLC_OFS_OD_STATUS: readMux = openDrain_reg;
         `PLC_OFS_PU_STATUS: readMux = pullOff_reg;
         `PLC_OFS_OW_STATUS: readMux = writePerm_reg;
         default: readMux = `PLC_RST_ZERO;
      endcase
   end

   // Read data held from the capture edge through the completing edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         readdata <= `PLC_RST_ZERO;
      end else if (capture) begin
         readdata <= read ? readMux : `PLC_RST_ZERO;
      end
   end

   // ==========================================================
   // Output enable, set and clear views
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         outEn_reg <= `PLC_RST_ZERO;
      end else if (wrAcc && address == `PLC_OFS_OUT_ENABLE) begin
         outEn_reg <= outEn_reg | writedata;
      end else if (wrAcc && address == `PLC_OFS_OUT_DISABLE) begin
         outEn_reg <= outEn_reg & ~writedata;
      end
   end

   // Glitch filter enable
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         filtEn_reg <= `PLC_RST_ZERO;
      end else if (wrAcc && address == `PLC_OFS_FILT_ENABLE) begin
         filtEn_reg <= filtEn_reg | writedata;
      end else if (wrAcc && address == `PLC_OFS_FILT_DISABLE) begin
         filtEn_reg <= filtEn_reg & ~writedata;
      end
   end

   // Scheduled drive value; direct writes honour write permission
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         outData_reg <= `PLC_RST_ZERO;
      end else if (wrAcc && address == `PLC_OFS_SET_OUTPUT) begin
         outData_reg <= outData_reg | writedata;
      end else if (wrAcc && address == `PLC_OFS_CLEAR_OUTPUT) begin
         outData_reg <= outData_reg & ~writedata;
      end else if (wrAcc && address == `PLC_OFS_OUT_DATA) begin
         outData_reg <= (outData_reg & ~writePerm_reg)
            | (writedata & writePerm_reg);
      end
   end

   // Write permission for the direct data register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         writePerm_reg <= `PLC_RST_ZERO;
      end else if (wrAcc && address == `PLC_OFS_OW_ENABLE) begin
         writePerm_reg <= writePerm_reg | writedata;
      end else if (wrAcc && address == `PLC_OFS_OW_DISABLE) begin
         writePerm_reg <= writePerm_reg & ~writedata;
      end
   end

   // Change interrupt mask
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irqMask_reg <= `PLC_RST_ZERO;
      end else if (wrAcc && address == `PLC_OFS_IRQ_ENABLE) begin
         irqMask_reg <= irqMask_reg | writedata;
      end else if (wrAcc && address == `PLC_OFS_IRQ_DISABLE) begin
         irqMask_reg <= irqMask_reg & ~writedata;
      end
   end

   // Open drain selection
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         openDrain_reg <= `PLC_RST_ZERO;
      end else if (wrAcc && address == `PLC_OFS_OD_ENABLE) begin
         openDrain_reg <= openDrain_reg | writedata;
      end else if (wrAcc && address == `PLC_OFS_OD_DISABLE) begin
         openDrain_reg <= openDrain_reg & ~writedata;
      end
   end

   // Pull-up off flags; zero means pull-up on
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pullOff_reg <= `PLC_RST_ZERO;
      end else if (wrAcc && address == `PLC_OFS_PU_DISABLE) begin
         pullOff_reg <= pullOff_reg | writedata;
      end else if (wrAcc && address == `PLC_OFS_PU_ENABLE) begin
         pullOff_reg <= pullOff_reg & ~writedata;
      end
   end

   // ==========================================================
   // Pad synchroniser, two stages before any logic
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1_reg <= `PLC_RST_ZERO;
         sync2_reg <= `PLC_RST_ZERO;
      end else begin
         sync1_reg <= padIn;
         sync2_reg <= sync1_reg;
      end
   end

   // Filter passes a level only after two equal samples
   assign stable = ~(sync2_reg ^ prevSamp_reg);
   assign filtNext = (sync2_reg & stable) | (filt_reg & ~stable);
   assign levelNext = (filtEn_reg & filt_reg) | (~filtEn_reg & sync2_reg);

   // Flops simply hold when the clock stops, so readback freezes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prevSamp_reg <= `PLC_RST_ZERO;
         filt_reg <= `PLC_RST_ZERO;
         level_reg <= `PLC_RST_ZERO;
         levelPrev_reg <= `PLC_RST_ZERO;
      end else begin
         prevSamp_reg <= sync2_reg;
         filt_reg <= filtNext;
         level_reg <= levelNext;
         levelPrev_reg <= level_reg;
      end
   end

   // Suppress a false change on the first cycle after reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         primed_reg <= 1'b0;
      end else begin
         primed_reg <= 1'b1;
      end
   end

   assign change = primed_reg ? (level_reg ^ levelPrev_reg) : `PLC_RST_ZERO;

   // ==========================================================
   // Change status; a new change wins over the read clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irqStat_reg <= `PLC_RST_ZERO;
      end else if (capture && read && address == `PLC_OFS_IRQ_STATUS) begin
         irqStat_reg <= change;
      end else begin
         irqStat_reg <= irqStat_reg | change;
      end
   end

   // Interrupt output from status and mask
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat_reg & irqMask_reg);
      end
   end

   // ==========================================================
   // Pad drivers, registered; open drain never drives high
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         padDrive.level <= `PLC_RST_ZERO;
         padDrive.enable <= `PLC_RST_ZERO;
         pullupOn <= ~`PLC_RST_ZERO;
      end else begin
         padDrive.level <= outData_reg & ~openDrain_reg;
         padDrive.enable <= outEn_reg & (~openDrain_reg | ~outData_reg);
         pullupOn <= ~pullOff_reg;
      end
   end
endmodule : plc_line_control

// ===== dv/plc_line_control_sva.sv
/* Port checker for the line controller.
 Assumes bind into plc_line_control and two cycles per bus transfer. */
`timescale 1ns/1ps
`include "plc_regs.svh"
module plc_line_control_sva (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [`PLC_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire plc_pkg::plc_lines_t padIn,
   input wire plc_pkg::plc_pad_drv_t padDrive,
   input wire plc_pkg::plc_lines_t pullupOn,
   input wire logic irq
);
   import plc_pkg::*;
   // ==========================================================
   // Bus timing
   default clocking dc @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no answer after capture");
   a_wait_pulse: assert property (!waitrequest |=> waitrequest)
      else $error("wait low too long");
   a_wait_idle: assert property (!read && !write && waitrequest |=> waitrequest)
      else $error("answer without request");
   a_read_stands: assert property (read && waitrequest |=> !waitrequest ##1 $stable(readdata))
      else $error("read data moved");
   a_write_zero: assert property (write && waitrequest |=> readdata == 32'h0)
      else $error("read data on write");
   // ==========================================================
   // Register effects at the pad and irq outputs, three edges after capture
   a_out_off: assert property (write && waitrequest && address == `PLC_OFS_OUT_DISABLE
      |-> ##3 (padDrive.enable & $past(writedata, 3)) == 32'h0)
      else $error("driver left on");
   a_line_keep: assert property (write && waitrequest && address == `PLC_OFS_OUT_DISABLE
      |-> ##3 (padDrive.enable & ~$past(writedata, 3))
      == ($past(padDrive.enable) & ~$past(writedata, 3)))
      else $error("other line changed");
   a_pullup_off: assert property (write && waitrequest && address == `PLC_OFS_PU_DISABLE
      |-> ##3 (pullupOn & $past(writedata, 3)) == 32'h0)
      else $error("pull-up left on");
   a_irq_masked: assert property (write && waitrequest && address == `PLC_OFS_IRQ_DISABLE
      && writedata == 32'hffff_ffff |-> ##3 !irq[*2])
      else $error("irq while all masked");
endmodule : plc_line_control_sva

bind plc_line_control plc_line_control_sva SVA (.clock(clock), .rst_n(rst_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .padIn(padIn),
   .padDrive(padDrive), .pullupOn(pullupOn), .irq(irq));

// ===== dv/plc_pad_model.sv
/* Pad wires outside the controller.
 Assumes the bench sets any outside drivers on extEn and extVal. */
`timescale 1ns/1ps
module plc_pad_model (
   input wire logic clock,
   input wire plc_pkg::plc_pad_drv_t padDrive,
   input wire plc_pkg::plc_lines_t pullupOn,
   input wire plc_pkg::plc_lines_t extEn,
   input wire plc_pkg::plc_lines_t extVal,
   output plc_pkg::plc_lines_t padIn
);
   import plc_pkg::*;
   plc_lines_t floatReg = '0;
   // Unpulled, undriven lines wander so a stale level is never trusted
   always_ff @(posedge clock) floatReg <= ~floatReg;
   // Own driver, then outside driver, then pull-up, else floating
   assign padIn = (padDrive.enable & padDrive.level)
      | (~padDrive.enable & extEn & extVal)
      | (~padDrive.enable & ~extEn & (pullupOn | floatReg));
endmodule : plc_pad_model

// ===== dv/test_plc_line_control.sv
/* Register and pad tests of the line controller.
 Assumes the pad model and the bound checker. */
`timescale 1ns/1ps
`include "plc_regs.svh"
module test_plc_line_control;
   import plc_pkg::*;
   logic clock = 0;
   logic rst_n = 0;
   logic [`PLC_ADDR_W-1:0] address = '0;
   logic read = 0;
   logic write = 0;
   logic [31:0] writedata = '0;
   logic [31:0] readdata;
   logic [31:0] q;
   logic waitrequest;
   logic irq;
   plc_lines_t padIn;
   plc_lines_t pullupOn;
   plc_lines_t extEn = '0;
   plc_lines_t extVal = '0;
   plc_pad_drv_t padDrive;
   int checked = 0;
   int miscompares = 0;
   localparam logic [31:0] A = 32'hf0f0_3c5a;
   localparam logic [31:0] B = 32'h3000_0f0a;
   // Set, clear and status offsets of each pair
   localparam logic [23:0] TR [6] = '{24'h101418, 24'h202428, 24'h303438,
      24'h404448, 24'h505458, 24'h606468};
   initial forever #2.5 clock = ~clock;
   plc_line_control DUT (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .padIn(padIn), .padDrive(padDrive),
      .pullupOn(pullupOn), .irq(irq));
   plc_pad_model PAD (.clock(clock), .padDrive(padDrive), .pullupOn(pullupOn),
      .extEn(extEn), .extVal(extVal), .padIn(padIn));
   // ==========================================================
   // Tasks
   task results;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Holds the request until waitrequest is sampled low at a rising edge
   task xfer(input logic rw, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      address <= a;
      writedata <= d;
      read <= !rw;
      write <= rw;
      n = 0;
      // Values read right after the edge are those the edge sampled
      do begin
         @(posedge clock);
         n++;
         if (n > 20) begin
            miscompares++;
            $display("BAD %0t bus stuck", $time);
            results();
         end
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 0;
      write <= 0;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1, a, d);
   endtask : wr
   task rc(input logic [7:0] a, input logic [31:0] e);
      xfer(0, a, 32'h0);
      chk(q, e);
   endtask : rc
   // ==========================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1;
      for (int i = 0; i < 6; i++) rc(TR[i][7:0], 32'h0);
      wr(8'h1c, 32'hffff_ffff);
      rc(8'h1c, 32'h0);
      $display("reset values done");
      for (int i = 0; i < 6; i++) begin
         wr(TR[i][23:16], A);
         wr(TR[i][23:16], 32'h0);
         wr(TR[i][7:0], 32'h0);
         wr(TR[i][15:8], B);
         rc(TR[i][7:0], A & ~B);
      end
      chk(pullupOn, ~(A & ~B));
      for (int i = 0; i < 6; i++) wr(TR[i][15:8], 32'hffff_ffff);
      $display("set clear status done");
      wr(`PLC_OFS_OUT_ENABLE, 32'hff);
      wr(`PLC_OFS_SET_OUTPUT, 32'h0f);
      repeat (8) @(posedge clock);
      rc(`PLC_OFS_PIN_LEVEL, 32'hffff_ff0f);
      wr(`PLC_OFS_OD_ENABLE, 32'h0f);
      repeat (4) @(posedge clock);
      chk(padDrive.enable & 32'hff, 32'hf0);
      wr(`PLC_OFS_PU_DISABLE, 32'h03);
      extEn <= 32'h1;
      repeat (8) @(posedge clock);
      // Line 1 floats with no pull-up, so its level is not compared
      xfer(0, `PLC_OFS_PIN_LEVEL, 32'h0);
      chk(q & 32'hffff_fffd, 32'hffff_ff0c);
      wr(`PLC_OFS_OW_ENABLE, 32'h00ff_0000);
      wr(`PLC_OFS_OUT_DATA, 32'hffff_ffff);
      rc(`PLC_OFS_OUT_DATA, 32'h00ff_000f);
      $display("pad drive done");
      wr(`PLC_OFS_IRQ_ENABLE, 32'h700);
      wr(`PLC_OFS_FILT_ENABLE, 32'h200);
      xfer(0, `PLC_OFS_IRQ_STATUS, 32'h0);
      extEn <= 32'h701;
      @(posedge clock);
      extEn <= 32'h101;
      repeat (10) @(posedge clock);
      chk(irq, 1'b1);
      xfer(0, `PLC_OFS_IRQ_STATUS, 32'h0);
      chk(q & 32'h700, 32'h500);
      xfer(0, `PLC_OFS_IRQ_STATUS, 32'h0);
      chk(q & 32'h700, 32'h0);
      repeat (3) @(posedge clock);
      chk(irq, 1'b0);
      wr(`PLC_OFS_IRQ_DISABLE, 32'hffff_ffff);
      $display("change status done");
      rst_n <= 0;
      repeat (2) @(posedge clock);
      rst_n <= 1;
      rc(`PLC_OFS_OUT_STATUS, 32'h0);
      $display("mid-run reset done");
      results();
   end
endmodule : test_plc_line_control
